//--- verilog/power_clock_sleep_ctrl.v
`include "power_clock_sleep_ctrl_defs.vh"
`default_nettype none

module power_clock_sleep_ctrl (
	input  wire                   ref_clk,           // Selected main clock
	input  wire                   rst,               // Synchronous reset, high
	input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr,      // Write address
	input  wire                   s_axi_awvalid,     // Write address valid
	output reg                    s_axi_awready,     // Write address ready
	input  wire [31:0]            s_axi_wdata,       // Write data
	input  wire [3:0]             s_axi_wstrb,       // Write byte strobes
	input  wire                   s_axi_wvalid,      // Write data valid
	output reg                    s_axi_wready,      // Write data ready
	output reg  [1:0]             s_axi_bresp,       // Write response
	output reg                    s_axi_bvalid,      // Write response valid
	input  wire                   s_axi_bready,      // Write response ready
	input  wire [`AXI_ADDR_W-1:0] s_axi_araddr,      // Read address
	input  wire                   s_axi_arvalid,     // Read address valid
	output reg                    s_axi_arready,     // Read address ready
	output reg  [31:0]            s_axi_rdata,       // Read data
	output reg  [1:0]             s_axi_rresp,       // Read response
	output reg                    s_axi_rvalid,      // Read data valid
	input  wire                   s_axi_rready,      // Read data ready
	input  wire                   accessProtect,     // Protection unit guards this block
	input  wire                   waitForInterrupt,  // CPU executes wait for interrupt
	input  wire                   sleepDeepSel,      // CPU deep sleep selection
	input  wire                   anyInterrupt,      // Pending unmasked interrupt
	input  wire                   asyncInterrupt,    // Asynchronous wake interrupt
	input  wire                   clockFailure,      // Main clock failure seen
	input  wire                   clocksReady,       // Clock sources ready event
	input  wire [7:0]             resetSources,      // Cause lines, held through reset
	output reg                    backupClockSelect, // Main clock from backup oscillator
	output reg                    cpuClkEn,          // CPU clock enable pulse
	output reg                    busAClkEn,         // Bus A clock enable pulse
	output reg                    busBClkEn,         // Bus B clock enable pulse
	output reg                    busCClkEn,         // Bus C clock enable pulse
	output reg  [4:0]             hsGateEn,          // High speed bus module gates
	output reg  [6:0]             busAGateEn,        // Bus A module gates
	output reg  [3:0]             busBGateEn,        // Bus B module gates
	output reg  [19:0]            busCGateEn,        // Bus C module gates
	output reg  [1:0]             sleepState,        // 0 active, 1 idle, 2 standby
	output reg                    irqRequest         // Interrupt request
);

	localparam [1:0] ST_ACTIVE  = 2'd0;
	localparam [1:0] ST_IDLE    = 2'd1;
	localparam [1:0] ST_STANDBY = 2'd2;

	// Byte-lane merge, used by the four gate registers
	function [31:0] mergeBytes;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0]  strb;
		integer      i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				mergeBytes[i*8 +: 8] = strb[i] ? newVal[i*8 +: 8] : oldVal[i*8 +: 8];
			end
		end
	endfunction

	// Address to register index; misaligned byte bits are ignored
	function [7:0] regIndex;
		input [`AXI_ADDR_W-1:0] addr;
		begin
			regIndex = addr[`AXI_ADDR_W-1:2];
		end
	endfunction

	// Mapped-register check, shared by read and write paths
	function isMapped;
		input [7:0] idx;
		begin
			case (idx)
				`IDX_MAIN_CLOCK_CONTROL, `IDX_IDLE_DEPTH_SELECT, `IDX_CPU_CLOCK_DIVIDER,
				`IDX_BUS_A_CLOCK_DIVIDER, `IDX_BUS_B_CLOCK_DIVIDER, `IDX_BUS_C_CLOCK_DIVIDER,
				`IDX_HS_BUS_CLOCK_GATES, `IDX_BUS_A_CLOCK_GATES, `IDX_BUS_B_CLOCK_GATES,
				`IDX_BUS_C_CLOCK_GATES, `IDX_IRQ_ENABLE_CLEAR, `IDX_IRQ_ENABLE_SET,
				`IDX_IRQ_FLAGS, `IDX_LAST_RESET_SOURCE: isMapped = 1'b1;
				default: isMapped = 1'b0;
			endcase
		end
	endfunction

	// Registers that the protection unit can lock
	function isProtected;
		input [7:0] idx;
		begin
			isProtected = isMapped(idx) && (idx < `IDX_IRQ_ENABLE_CLEAR);
		end
	endfunction

	reg  [7:0]  control_r;
	reg  [1:0]  idleDepth_r;
	reg  [2:0]  cpu_divider_field_r;
	reg  [2:0]  busADiv_r;
	reg  [2:0]  busBDiv_r;
	reg  [2:0]  busCDiv_r;
	reg  [31:0] hsGates_r;
	reg  [31:0] aGates_r;
	reg  [31:0] bGates_r;
	reg  [31:0] cGates_r;
	reg  [1:0]  irqEnable_r;
	reg  [1:0]  irqFlags_r;
	reg  [7:0]  resetCause_r;
	reg         causeCapture_r;
	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg         awHeld_r;
	reg         wHeld_r;
	reg  [7:0]  wrIdx_r;
	reg  [31:0] wrData_r;
	reg  [3:0]  wrStrb_r;
	reg  [31:0] rdVal;
	wire        wrGo;
	wire        wrOk;
	wire [7:0]  rdIdx;
	wire        frozen;
	wire        cpuRun;
	wire        ahbRun;
	wire        apbRun;
	wire        failEvent;
	wire [1:0]  flagSet;
	wire [1:0]  flagClr;
	wire [1:0]  enSet;
	wire [1:0]  enClr;
	wire [3:0]  ticks;
	wire [3:0]  domRun;
	wire [11:0] divSel;

	// Write happens once address and data are both held
	assign wrGo  = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign wrOk  = isMapped(wrIdx_r) && !(accessProtect && isProtected(wrIdx_r));
	assign rdIdx = regIndex(s_axi_araddr);

	// Standby stops every domain; idle keeps this block itself on the main clock
	assign frozen = (state_r == ST_STANDBY);
	assign cpuRun = (state_r == ST_ACTIVE);
	assign ahbRun = cpuRun || ((state_r == ST_IDLE) && (idleDepth_r == `IDLE_CPU));
	assign apbRun = ahbRun || ((state_r == ST_IDLE) && (idleDepth_r == `IDLE_AHB));

	// Event sources; hardware sets take priority over software clears
	assign failEvent = clockFailure && control_r[`BIT_FAILURE_DETECTOR_ENABLE] && !frozen;
	assign flagSet   = {failEvent, clocksReady && !frozen};
	assign flagClr   = (wrGo && wrOk && (wrIdx_r == `IDX_IRQ_FLAGS) && wrStrb_r[0]) ?
	                   wrData_r[1:0] : 2'b00;
	assign enSet     = (wrGo && wrOk && (wrIdx_r == `IDX_IRQ_ENABLE_SET) && wrStrb_r[0]) ?
	                   wrData_r[1:0] : 2'b00;
	assign enClr     = (wrGo && wrOk && (wrIdx_r == `IDX_IRQ_ENABLE_CLEAR) && wrStrb_r[0]) ?
	                   wrData_r[1:0] : 2'b00;

	// Sleep sequencer
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_ACTIVE: begin
				if (waitForInterrupt) begin
					state_nxt = sleepDeepSel ? ST_STANDBY : ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (anyInterrupt) begin
					state_nxt = ST_ACTIVE;
				end
			end
			ST_STANDBY: begin
				if (asyncInterrupt) begin
					state_nxt = ST_ACTIVE;
				end
			end
			default: state_nxt = ST_ACTIVE;
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_ACTIVE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Write channel: address and data accepted in either order
	always @(posedge ref_clk) begin
		if (rst) begin
			awHeld_r      <= 1'b0;
			wHeld_r       <= 1'b0;
			wrIdx_r       <= 8'h00;
			wrData_r      <= 32'h0000_0000;
			wrStrb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !awHeld_r && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				awHeld_r      <= 1'b1;
				wrIdx_r       <= regIndex(s_axi_awaddr);
			end
			if (s_axi_wvalid && !wHeld_r && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				wHeld_r      <= 1'b1;
				wrData_r     <= s_axi_wdata;
				wrStrb_r     <= s_axi_wstrb;
			end
			if (wrGo) begin
				awHeld_r     <= 1'b0;
				wHeld_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (!isMapped(wrIdx_r)) begin
					s_axi_bresp <= `RESP_DECERR;
				end else if (!wrOk) begin
					s_axi_bresp <= `RESP_SLVERR;
				end else begin
					s_axi_bresp <= `RESP_OKAY;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read mux; narrow registers in the low bits, the rest reads zero
	always @* begin
		rdVal = 32'h0000_0000;
		case (rdIdx)
			`IDX_MAIN_CLOCK_CONTROL:  rdVal[7:0] = control_r;
			`IDX_IDLE_DEPTH_SELECT:   rdVal[1:0] = idleDepth_r;
			`IDX_CPU_CLOCK_DIVIDER:   rdVal[2:0] = cpu_divider_field_r;
			`IDX_BUS_A_CLOCK_DIVIDER: rdVal[2:0] = busADiv_r;
			`IDX_BUS_B_CLOCK_DIVIDER: rdVal[2:0] = busBDiv_r;
			`IDX_BUS_C_CLOCK_DIVIDER: rdVal[2:0] = busCDiv_r;
			`IDX_HS_BUS_CLOCK_GATES:  rdVal = hsGates_r & `HS_GATE_BITS;
			`IDX_BUS_A_CLOCK_GATES:   rdVal = aGates_r & `A_GATE_BITS;
			`IDX_BUS_B_CLOCK_GATES:   rdVal = bGates_r & `B_GATE_BITS;
			`IDX_BUS_C_CLOCK_GATES:   rdVal = cGates_r & `C_GATE_BITS;
			`IDX_IRQ_ENABLE_CLEAR:    rdVal[1:0] = irqEnable_r;
			`IDX_IRQ_ENABLE_SET:      rdVal[1:0] = irqEnable_r;
			`IDX_IRQ_FLAGS:           rdVal[1:0] = irqFlags_r;
			`IDX_LAST_RESET_SOURCE:   rdVal[7:0] = resetCause_r;
			default:                  rdVal = 32'h0000_0000;
		endcase
	end

	// Read channel: one read at a time, data one cycle after address
	always @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rdVal;
				s_axi_rresp   <= isMapped(rdIdx) ? `RESP_OKAY : `RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Configuration registers; byte lanes honoured, divider bytes use lane 0 only
	always @(posedge ref_clk) begin
		if (rst) begin
			control_r   <= `RST_CONTROL;
			idleDepth_r <= `RST_IDLE_DEPTH;
			cpu_divider_field_r    <= `RST_DIVIDER;
			busADiv_r   <= `RST_DIVIDER;
			busBDiv_r   <= `RST_DIVIDER;
			busCDiv_r   <= `RST_DIVIDER;
			hsGates_r   <= `RST_HS_GATES;
			aGates_r    <= `RST_A_GATES;
			bGates_r    <= `RST_B_GATES;
			cGates_r    <= `RST_C_GATES;
		end else begin
			if (wrGo && wrOk && wrStrb_r[0]) begin
				case (wrIdx_r)
					`IDX_MAIN_CLOCK_CONTROL: begin
						control_r <= wrData_r[7:0] & 8'h14;
					end
					`IDX_IDLE_DEPTH_SELECT:   idleDepth_r <= wrData_r[1:0];
					`IDX_CPU_CLOCK_DIVIDER:   cpu_divider_field_r    <= wrData_r[2:0];
					`IDX_BUS_A_CLOCK_DIVIDER: busADiv_r   <= wrData_r[2:0];
					`IDX_BUS_B_CLOCK_DIVIDER: busBDiv_r   <= wrData_r[2:0];
					`IDX_BUS_C_CLOCK_DIVIDER: busCDiv_r   <= wrData_r[2:0];
					default: begin
					end
				endcase
			end
			if (wrGo && wrOk) begin
				case (wrIdx_r)
					`IDX_HS_BUS_CLOCK_GATES: hsGates_r <= mergeBytes(hsGates_r, wrData_r, wrStrb_r);
					`IDX_BUS_A_CLOCK_GATES:  aGates_r  <= mergeBytes(aGates_r, wrData_r, wrStrb_r);
					`IDX_BUS_B_CLOCK_GATES:  bGates_r  <= mergeBytes(bGates_r, wrData_r, wrStrb_r);
					`IDX_BUS_C_CLOCK_GATES:  cGates_r  <= mergeBytes(cGates_r, wrData_r, wrStrb_r);
					default: begin
					end
				endcase
			end
			// Failure forces the backup clock even over a same-cycle write
			if (failEvent) begin
				control_r[`BIT_BACKUP_CLOCK_SELECT]     <= 1'b1;
				control_r[`BIT_FAILURE_DETECTOR_ENABLE] <= 1'b1;
			end
		end
	end

	// Interrupt enable and flags; set wins over clear
	always @(posedge ref_clk) begin
		if (rst) begin
			irqEnable_r <= 2'b00;
			irqFlags_r  <= 2'b00;
			irqRequest  <= 1'b0;
		end else begin
			irqEnable_r <= (irqEnable_r & ~enClr) | enSet;
			irqFlags_r  <= (irqFlags_r & ~flagClr) | flagSet;
			irqRequest  <= |(((irqFlags_r & ~flagClr) | flagSet) & ((irqEnable_r & ~enClr) | enSet));
		end
	end

	// Reset cause caught on the first edge after release, lines still valid then
	always @(posedge ref_clk) begin
		if (rst) begin
			causeCapture_r <= 1'b1;
			resetCause_r   <= 8'h00;
		end else begin
			causeCapture_r <= 1'b0;
			if (causeCapture_r) begin
				resetCause_r <= resetSources & `CAUSE_BITS;
			end
		end
	end

	// Four prescalers: CPU on its own domain, buses A to C on the APB domain
	assign domRun = {apbRun, apbRun, apbRun, cpuRun};
	assign divSel = {busCDiv_r, busBDiv_r, busADiv_r, cpu_divider_field_r};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gPrescale
			clock_prescaler uPrescale (
				.ref_clk (ref_clk),
				.rst     (rst),
				.run     (domRun[g] && !frozen),
				.divSel  (divSel[g*3 +: 3]),
				.tick    (ticks[g])
			);
		end
	endgenerate

	// Registered outputs; gates close while their domain sleeps
	always @(posedge ref_clk) begin
		if (rst) begin
			backupClockSelect <= 1'b0;
			cpuClkEn          <= 1'b0;
			busAClkEn         <= 1'b0;
			busBClkEn         <= 1'b0;
			busCClkEn         <= 1'b0;
			hsGateEn          <= 5'h00;
			busAGateEn        <= 7'h00;
			busBGateEn        <= 4'h0;
			busCGateEn        <= 20'h0_0000;
			sleepState        <= ST_ACTIVE;
		end else begin
			backupClockSelect <= control_r[`BIT_BACKUP_CLOCK_SELECT];
			cpuClkEn          <= ticks[0];
			busAClkEn         <= ticks[1];
			busBClkEn         <= ticks[2];
			busCClkEn         <= ticks[3];
			hsGateEn          <= hsGates_r[4:0] & {5{ahbRun}};
			busAGateEn        <= aGates_r[6:0] & {7{apbRun}};
			busBGateEn        <= bGates_r[3:0] & {4{apbRun}};
			busCGateEn        <= cGates_r[19:0] & {20{apbRun}};
			sleepState        <= state_r;
		end
	end

endmodule // power_clock_sleep_ctrl

`default_nettype wire

//--- inc/power_clock_sleep_ctrl_defs.vh
`ifndef POWER_CLOCK_SLEEP_CTRL_DEFS_VH
`define POWER_CLOCK_SLEEP_CTRL_DEFS_VH

// Register indices; byte address on the bus is four times the index
`define IDX_MAIN_CLOCK_CONTROL   8'h00
`define IDX_IDLE_DEPTH_SELECT    8'h01
`define IDX_CPU_CLOCK_DIVIDER    8'h08
`define IDX_BUS_A_CLOCK_DIVIDER  8'h09
`define IDX_BUS_B_CLOCK_DIVIDER  8'h0A
`define IDX_BUS_C_CLOCK_DIVIDER  8'h0B
`define IDX_HS_BUS_CLOCK_GATES   8'h14
`define IDX_BUS_A_CLOCK_GATES    8'h18
`define IDX_BUS_B_CLOCK_GATES    8'h1C
`define IDX_BUS_C_CLOCK_GATES    8'h20
`define IDX_IRQ_ENABLE_CLEAR     8'h34
`define IDX_IRQ_ENABLE_SET       8'h35
`define IDX_IRQ_FLAGS            8'h36
`define IDX_LAST_RESET_SOURCE    8'h38

// Bus widths
`define AXI_ADDR_W 10

// Main clock control fields
`define BIT_BACKUP_CLOCK_SELECT     4
`define BIT_FAILURE_DETECTOR_ENABLE 2

// Interrupt flag fields
`define BIT_CLOCKS_READY_FLAG  0
`define BIT_CLOCK_FAILURE_FLAG 1

// Last reset source fields
`define BIT_POWER_ON_CAUSE      0
`define BIT_CORE_BROWNOUT_CAUSE 1
`define BIT_IO_BROWNOUT_CAUSE   2
`define BIT_EXT_PIN_CAUSE       4
`define BIT_WATCHDOG_CAUSE      5
`define BIT_SYSTEM_REQUEST_CAUSE 6
`define CAUSE_BITS 8'h77

// Idle depth codes
`define IDLE_CPU 2'h0
`define IDLE_AHB 2'h1
`define IDLE_APB 2'h2

// Reset values
`define RST_CONTROL     8'h00
`define RST_IDLE_DEPTH  2'h0
`define RST_DIVIDER     3'h0
`define RST_HS_GATES    32'h0000_007F
`define RST_A_GATES     32'h0000_007F
`define RST_B_GATES     32'h0000_000F
`define RST_C_GATES     32'h0000_0000

// Implemented bits of the gate registers
`define HS_GATE_BITS    32'h0000_001F
`define A_GATE_BITS     32'h0000_007F
`define B_GATE_BITS     32'h0000_000F
`define C_GATE_BITS     32'h000F_FFFF

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

//--- verilog/clock_prescaler.v
`default_nettype none

// Power-of-two clock enable generator
module clock_prescaler (
	input  wire       ref_clk, // Main clock
	input  wire       rst,     // Synchronous reset, high
	input  wire       run,     // Domain running
	input  wire [2:0] divSel,  // Divide by 2^divSel
	output reg        tick     // Enable pulse, one per period
);

	reg  [6:0] count_r;
	wire [6:0] limit;

	// Mask of low counter bits; all ones ends the period
	assign limit = (7'h7F >> (3'd7 - divSel));

	// Counter halts while the domain is stopped, so no stale tick on restart
	always @(posedge ref_clk) begin
		if (rst) begin
			count_r <= 7'h00;
			tick    <= 1'b0;
		end else if (run) begin
			count_r <= count_r + 7'h01;
			tick    <= ((count_r & limit) == limit);
		end else begin
			tick    <= 1'b0;
		end
	end

endmodule // clock_prescaler

`default_nettype wire

//--- test/power_clock_sleep_ctrl_asserts.sv
`include "power_clock_sleep_ctrl_defs.vh"
`default_nettype none

module power_clock_sleep_ctrl_asserts (
	input wire logic        ref_clk,           // Main clock
	input wire logic        rst,               // Reset, high
	input wire logic        s_axi_arvalid,     // Read address valid
	input wire logic        s_axi_arready,     // Read address ready
	input wire logic        s_axi_rvalid,      // Read data valid
	input wire logic        s_axi_awready,     // Write address ready
	input wire logic        s_axi_wready,      // Write data ready
	input wire logic        s_axi_bvalid,      // Write response valid
	input wire logic        waitForInterrupt,  // Sleep request
	input wire logic        sleepDeepSel,      // Deep sleep choice
	input wire logic        anyInterrupt,      // Idle wake
	input wire logic        asyncInterrupt,    // Standby wake
	input wire logic        clockFailure,      // Failure event
	input wire logic        clocksReady,       // Ready event
	input wire logic        backupClockSelect, // Backup clock in use
	input wire logic        cpuClkEn,          // CPU enable pulse
	input wire logic [4:0]  hsGateEn,          // High speed gates
	input wire logic [6:0]  busAGateEn,        // Bus A gates
	input wire logic [3:0]  busBGateEn,        // Bus B gates
	input wire logic [19:0] busCGateEn,        // Bus C gates
	input wire logic [1:0]  sleepState,        // Sleep state
	input wire logic        irqRequest         // Interrupt request
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Bus answers
	AST_READ_ANSWER: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
		else $error("read not answered one cycle after request");
	AST_WRITE_RESP: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready) || $past(s_axi_wready))
		else $error("write response without a handshake just before");

	// State straight after reset
	AST_RESET_BACKUP: assert property ($fell(rst) |-> !backupClockSelect && sleepState == 2'h0)
		else $error("backup clock or sleep state not clear after reset");
	AST_RESET_GATES: assert property ($fell(rst) |=> hsGateEn == 5'h1F && busAGateEn == 7'h7F
		&& busBGateEn == 4'hF && busCGateEn == 20'h0_0000)
		else $error("gates differ from reset masks");

	// Sleep entry, hold and wake; wake pulses are one cycle, hence the past term
	AST_IDLE_ENTRY: assert property (waitForInterrupt && !sleepDeepSel && !anyInterrupt && sleepState == 2'h0 |-> ##2 sleepState == 2'h1)
		else $error("idle not entered two cycles after request");
	AST_STANDBY_ENTRY: assert property (waitForInterrupt && sleepDeepSel && sleepState == 2'h0 |-> ##2 sleepState == 2'h2)
		else $error("standby not entered two cycles after request");
	AST_STANDBY_HOLD: assert property (sleepState == 2'h2 && !asyncInterrupt && !$past(asyncInterrupt) |=> sleepState == 2'h2)
		else $error("standby left without a wake interrupt");
	AST_STANDBY_WAKE: assert property (sleepState == 2'h2 && asyncInterrupt |-> ##[1:2] sleepState == 2'h0)
		else $error("standby not left after wake interrupt");
	AST_IDLE_CPU_STOP: assert property (sleepState != 2'h0 && $past(sleepState) != 2'h0 |-> !cpuClkEn)
		else $error("cpu enable pulse while sleeping");

	// Request only follows an event or a register write
	AST_IRQ_CAUSE: assert property ($rose(irqRequest) |-> $past(clockFailure) || $past(clocksReady)
		|| $past(clockFailure, 2) || $past(clocksReady, 2) || s_axi_bvalid || $past(s_axi_bvalid))
		else $error("interrupt request without a cause");

	// Main scenarios reached
	COV_IDLE: cover property (sleepState == 2'h1);
	COV_STANDBY: cover property (sleepState == 2'h2);
	COV_IRQ: cover property ($rose(irqRequest));
endmodule // power_clock_sleep_ctrl_asserts

bind power_clock_sleep_ctrl power_clock_sleep_ctrl_asserts u_power_clock_sleep_ctrl_asserts (
	.ref_clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .waitForInterrupt, .sleepDeepSel, .anyInterrupt, .asyncInterrupt, .clockFailure,
	.clocksReady, .backupClockSelect, .cpuClkEn, .hsGateEn, .busAGateEn, .busBGateEn, .busCGateEn,
	.sleepState, .irqRequest);

`default_nettype wire

//--- test/test_power_clock_sleep_ctrl.sv
`include "power_clock_sleep_ctrl_defs.vh"
`default_nettype none

module test_power_clock_sleep_ctrl;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, accessProtect, waitForInterrupt, sleepDeepSel, anyInterrupt;
	logic        asyncInterrupt, clockFailure, clocksReady, backupClockSelect, irqRequest;
	logic        cpuClkEn, busAClkEn, busBClkEn, busCClkEn;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, busBGateEn;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sleepState;
	logic [7:0]  resetSources;
	logic [4:0]  hsGateEn;
	logic [6:0]  busAGateEn;
	logic [19:0] busCGateEn;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	power_clock_sleep_ctrl u_power_clock_sleep_ctrl (.*);

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	// Write one word; an edge passes first so no signal is set twice in a step
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		check({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, exp);
		check({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
	endtask

	task automatic t_reset();
		rd(`IDX_MAIN_CLOCK_CONTROL, 32'h0000_0000, `RESP_OKAY);
		rd(`IDX_IDLE_DEPTH_SELECT, 32'h0000_0000, `RESP_OKAY);
		rd(`IDX_CPU_CLOCK_DIVIDER, 32'h0000_0000, `RESP_OKAY);
		rd(`IDX_BUS_A_CLOCK_DIVIDER, 32'h0000_0000, `RESP_OKAY);
		rd(`IDX_HS_BUS_CLOCK_GATES, 32'h0000_001F, `RESP_OKAY);
		rd(`IDX_BUS_A_CLOCK_GATES, 32'h0000_007F, `RESP_OKAY);
		rd(`IDX_LAST_RESET_SOURCE, 32'h0000_0025, `RESP_OKAY);
		check(backupClockSelect, 1'b0);
	endtask

	// Lanes, unused bits, unmapped place, backup select output
	task automatic t_rw();
		wr(`IDX_BUS_A_CLOCK_DIVIDER, 32'h0000_00FD, 4'h1, `RESP_OKAY);
		rd(`IDX_BUS_A_CLOCK_DIVIDER, 32'h0000_0005, `RESP_OKAY);
		wr(`IDX_BUS_A_CLOCK_DIVIDER, 32'h0000_0002, 4'h2, `RESP_OKAY);
		rd(`IDX_BUS_A_CLOCK_DIVIDER, 32'h0000_0005, `RESP_OKAY);
		wr(`IDX_BUS_C_CLOCK_GATES, 32'hFFFF_FFFF, 4'h4, `RESP_OKAY);
		rd(`IDX_BUS_C_CLOCK_GATES, 32'h000F_0000, `RESP_OKAY);
		wr(`IDX_BUS_C_CLOCK_GATES, 32'h0000_1234, 4'hF, `RESP_OKAY);
		cyc(2);
		check(busCGateEn, 20'h0_1234);
		wr(8'h02, 32'h0000_0001, 4'hF, `RESP_DECERR);
		rd(8'h02, 32'h0000_0000, `RESP_DECERR);
		wr(`IDX_MAIN_CLOCK_CONTROL, 32'h0000_0010, 4'h1, `RESP_OKAY);
		cyc(2);
		check(backupClockSelect, 1'b1);
	endtask

	task automatic t_protect();
		accessProtect <= 1'b1;
		wr(`IDX_IDLE_DEPTH_SELECT, 32'h0000_0002, 4'h1, `RESP_SLVERR);
		rd(`IDX_IDLE_DEPTH_SELECT, 32'h0000_0000, `RESP_OKAY);
		wr(`IDX_IRQ_ENABLE_CLEAR, 32'h0000_0003, 4'h1, `RESP_OKAY);
		wr(`IDX_IRQ_ENABLE_SET, 32'h0000_0001, 4'h1, `RESP_OKAY);
		rd(`IDX_IRQ_ENABLE_SET, 32'h0000_0001, `RESP_OKAY);
		accessProtect <= 1'b0;
	endtask

	// Count enable pulses over 256 cycles after the divider settles
	task automatic count_div(input logic [7:0] idx, input logic [2:0] k);
		int cnt;
		cnt = 0;
		wr(idx, {29'h0, k}, 4'h1, `RESP_OKAY);
		cyc(140);
		repeat (256) begin
			@(posedge ref_clk);
			cnt += (idx == `IDX_CPU_CLOCK_DIVIDER) ? cpuClkEn :
				(idx == `IDX_BUS_A_CLOCK_DIVIDER) ? busAClkEn :
				(idx == `IDX_BUS_B_CLOCK_DIVIDER) ? busBClkEn : busCClkEn;
		end
		check(cnt, 256 >> k);
	endtask

	task automatic t_div();
		for (int k = 0; k < 8; k++) count_div(`IDX_CPU_CLOCK_DIVIDER, 3'(k));
		count_div(`IDX_BUS_A_CLOCK_DIVIDER, 3'h7);
		count_div(`IDX_BUS_B_CLOCK_DIVIDER, 3'h3);
		count_div(`IDX_BUS_C_CLOCK_DIVIDER, 3'h5);
	endtask

	// Each idle depth; the bus still answers while idle
	task automatic t_idle();
		for (int d = 0; d < 3; d++) begin
			wr(`IDX_IDLE_DEPTH_SELECT, 32'(d), 4'h1, `RESP_OKAY);
			waitForInterrupt <= 1'b1;
			@(posedge ref_clk);
			waitForInterrupt <= 1'b0;
			cyc(3);
			check(sleepState, 2'h1);
			check({hsGateEn, busAGateEn, busBGateEn},
				d == 0 ? 16'hFFFF : d == 1 ? 16'h07FF : 16'h0000);
			rd(`IDX_IDLE_DEPTH_SELECT, 32'(d), `RESP_OKAY);
			anyInterrupt <= 1'b1;
			@(posedge ref_clk);
			anyInterrupt <= 1'b0;
			cyc(3);
			check(sleepState, 2'h0);
		end
	endtask

	// Only the asynchronous wake leaves standby; events are frozen
	task automatic t_standby();
		wr(`IDX_IRQ_FLAGS, 32'h0000_0003, 4'h1, `RESP_OKAY);
		sleepDeepSel <= 1'b1;
		waitForInterrupt <= 1'b1;
		@(posedge ref_clk);
		waitForInterrupt <= 1'b0;
		sleepDeepSel <= 1'b0;
		cyc(3);
		check(sleepState, 2'h2);
		anyInterrupt <= 1'b1;
		clocksReady <= 1'b1;
		cyc(4);
		check(sleepState, 2'h2);
		anyInterrupt <= 1'b0;
		clocksReady <= 1'b0;
		asyncInterrupt <= 1'b1;
		@(posedge ref_clk);
		asyncInterrupt <= 1'b0;
		cyc(3);
		check(sleepState, 2'h0);
		rd(`IDX_IRQ_FLAGS, 32'h0000_0000, `RESP_OKAY);
	endtask

	task automatic t_events();
		wr(`IDX_MAIN_CLOCK_CONTROL, 32'h0000_0004, 4'h1, `RESP_OKAY);
		wr(`IDX_IRQ_ENABLE_CLEAR, 32'h0000_0003, 4'h1, `RESP_OKAY);
		wr(`IDX_IRQ_ENABLE_SET, 32'h0000_0002, 4'h1, `RESP_OKAY);
		cyc(2);
		check({irqRequest, backupClockSelect}, 2'b00);
		clocksReady <= 1'b1;
		@(posedge ref_clk);
		clocksReady <= 1'b0;
		cyc(3);
		check(irqRequest, 1'b0);
		clockFailure <= 1'b1;
		@(posedge ref_clk);
		clockFailure <= 1'b0;
		cyc(3);
		check({irqRequest, backupClockSelect}, 2'b11);
		rd(`IDX_MAIN_CLOCK_CONTROL, 32'h0000_0014, `RESP_OKAY);
		rd(`IDX_IRQ_FLAGS, 32'h0000_0003, `RESP_OKAY);
		wr(`IDX_IRQ_FLAGS, 32'h0000_0002, 4'h1, `RESP_OKAY);
		cyc(2);
		check(irqRequest, 1'b0);
		wr(`IDX_IRQ_ENABLE_SET, 32'h0000_0001, 4'h1, `RESP_OKAY);
		cyc(2);
		check(irqRequest, 1'b1);
		wr(`IDX_IRQ_ENABLE_CLEAR, 32'h0000_0001, 4'h1, `RESP_OKAY);
		cyc(2);
		check(irqRequest, 1'b0);
		rd(`IDX_IRQ_ENABLE_SET, 32'h0000_0002, `RESP_OKAY);
	endtask

	// Watchdog, 20k cycles against roughly five thousand needed
	initial begin
		#400_000;
		n_mismatch++;
		finish_test();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		resetSources = 8'hA5;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{accessProtect, waitForInterrupt, sleepDeepSel, anyInterrupt, asyncInterrupt} = '0;
		{clockFailure, clocksReady, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(3);
		t_reset();
		t_rw();
		t_protect();
		t_div();
		t_idle();
		t_standby();
		t_events();
		finish_test();
	end
endmodule // test_power_clock_sleep_ctrl

`default_nettype wire
